// ---- pmm_core.sv ----
/*
  Program memory map: PC, vectors, top-of-flash decode, zero fill,
  configuration load from the top of flash and interrupt wake entry.
  Assumes the flash answers a byte read with flash_valid some cycles
  after flash_req; the data bus is a separate port set (not here).
*/
// Notes on behaviour
// - Program counter is 21 bits, 2 Mbyte space
// - Reads above implemented flash return zeros
// - Program bus separate from data bus
// - Flash size 64, 96 or 128 Kbytes
// - Every reset sends PC to zero
// - High vector 0x0008, low vector 0x0018
// - Top four words hold configuration
// - Reset copies configuration words into registers
// - Configuration bytes ascend, low byte first
// - Fourth word reserved, never loaded
// - Interrupt wake pushes PC, advances pointer up to 31, where it holds
// - Interrupt wake loads matching vector
// - Wake leaves other register contents unchanged
// - Stack: 31 entries, 21 bits, 5-bit pointer
`timescale 1ns/10ps
module pmm_core
  import pmm_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic [1:0]          flash_size,
  // Fetch side
  input  wire logic                fetch_req,
  input  wire logic [PMM_PC_W-1:0] fetch_addr,
  output logic                     fetch_valid,
  output logic [7:0]               fetch_data,
  input  wire logic                pc_load,
  input  wire logic [PMM_PC_W-1:0] pc_load_value,
  input  wire logic                pc_step,
  input  wire logic                stack_pop,
  // Interrupt wake
  input  wire logic                wake_irq,
  input  wire logic                wake_irq_high,
  input  wire logic                global_irq_enable_high,
  input  wire logic                global_irq_enable_low,
  // Flash array side
  output logic                     flash_req,
  output logic [PMM_PC_W-1:0]      flash_addr,
  input  wire logic                flash_valid,
  input  wire logic [7:0]          flash_data,
  // Results
  output logic [PMM_PC_W-1:0]      pc,
  output logic                     core_run,
  output logic [15:0]              setup_word_one,
  output logic [15:0]              setup_word_two,
  output logic [15:0]              setup_word_three,
  output logic [PMM_SP_W-1:0]      return_stack_pointer,
  output logic [7:0]               stack_top_upper,
  output logic [7:0]               stack_top_high,
  output logic [7:0]               stack_top_low
);
  function automatic logic [PMM_PC_W-1:0] top_of_flash(input logic [1:0] sz);
    case (sz)
      PMM_SIZE_96K:  top_of_flash = PMM_TOP_96K;
      PMM_SIZE_128K: top_of_flash = PMM_TOP_128K;
      default:       top_of_flash = PMM_TOP_64K;
    endcase
  endfunction : top_of_flash

  pmm_state_t          state;
  logic [2:0]          cfg_idx;
  logic [1:0]          size_lat;
  logic [PMM_PC_W-1:0] mem_top;
  logic                fetch_pend;
  logic                fetch_zero;
  logic                wake_enter;
  logic [PMM_PC_W-1:0] tos;

  assign mem_top    = top_of_flash(size_lat);
  assign core_run   = (state == PMM_RUN);
  assign wake_enter = core_run && wake_irq && (global_irq_enable_high || global_irq_enable_low);
  assign stack_top_upper = {3'h0, tos[20:16]};
  assign stack_top_high  = tos[15:8];
  assign stack_top_low   = tos[7:0];

  // Size sampled once after reset so decode cannot shift mid-run
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      size_lat <= PMM_SIZE_64K;
    end else if (state == PMM_LOAD_REQ && cfg_idx == 3'h0) begin
      size_lat <= flash_size;
    end
  end

  // Loader: bytes in ascending address order, reserved word skipped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= PMM_LOAD_REQ;
      cfg_idx <= 3'h0;
    end else begin
      case (state)
        PMM_LOAD_REQ:  state <= PMM_LOAD_WAIT;
        PMM_LOAD_WAIT: begin
          if (flash_valid) begin
            cfg_idx <= cfg_idx + 3'h1;
            state   <= (cfg_idx == PMM_CFG_USED) ? PMM_RUN : PMM_LOAD_REQ;
          end
        end
        PMM_RUN:       state <= PMM_RUN;
        default:       state <= PMM_LOAD_REQ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_word_one   <= PMM_CFG_RESET;
      setup_word_two   <= PMM_CFG_RESET;
      setup_word_three <= PMM_CFG_RESET;
    end else if (state == PMM_LOAD_WAIT && flash_valid) begin
      case (cfg_idx)
        3'h0:    setup_word_one[7:0]    <= flash_data;
        3'h1:    setup_word_one[15:8]   <= flash_data;
        3'h2:    setup_word_two[7:0]    <= flash_data;
        3'h3:    setup_word_two[15:8]   <= flash_data;
        3'h4:    setup_word_three[7:0]  <= flash_data;
        default: setup_word_three[15:8] <= flash_data;
      endcase
    end
  end

  // Flash request: config reads while loading, fetches once running
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_req  <= 1'b0;
      flash_addr <= '0;
    end else if (state == PMM_LOAD_REQ) begin
      flash_req  <= 1'b1;
      flash_addr <= top_of_flash(cfg_idx == 3'h0 ? flash_size : size_lat)
                    - PMM_CFG_BYTES + {18'h0, cfg_idx};
    end else if (core_run && fetch_req && !fetch_pend && fetch_addr < mem_top) begin
      flash_req  <= 1'b1;
      flash_addr <= fetch_addr;
    end else begin
      flash_req  <= 1'b0;
    end
  end

  // A fetch above the top never reaches flash; the zero byte is made here
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_pend  <= 1'b0;
      fetch_zero  <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_data  <= 8'h00;
    end else begin
      fetch_valid <= 1'b0;
      fetch_zero  <= 1'b0;
      if (core_run && fetch_req && !fetch_pend) begin
        fetch_pend <= 1'b1;
        fetch_zero <= (fetch_addr >= mem_top);
      end else if (fetch_pend && fetch_zero) begin
        fetch_pend  <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_data  <= 8'h00;
      end else if (fetch_pend && flash_valid) begin
        fetch_pend  <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_data  <= flash_data;
      end
    end
  end

  // PC: wake entry beats load, which beats step; other registers hold
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= PMM_RESET_VEC;
    end else if (!core_run) begin
      pc <= PMM_RESET_VEC;
    end else if (wake_enter) begin
      pc <= wake_irq_high ? PMM_HIGH_VEC : PMM_LOW_VEC;
    end else if (pc_load) begin
      pc <= {pc_load_value[PMM_PC_W-1:1], 1'b0};
    end else if (pc_step) begin
      pc <= pc + 21'h000002;
    end
  end

  // Wake wins over pop, so one edge never both pushes and pops
  pmm_stack #(.DEPTH(PMM_STACK_DEPTH)) u_stack (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .push                 (wake_enter),
    .pop                  (stack_pop && !wake_enter),
    .push_data            (pc),
    .return_stack_pointer (return_stack_pointer),
    .stack_top            (tos)
  );

  // All checks sit in the single mclk domain and sleep during reset
  property p_vec;
    @(posedge mclk) disable iff (sys_rst)
    wake_enter |=> (pc == ($past(wake_irq_high) ? PMM_HIGH_VEC : PMM_LOW_VEC));
  endproperty
  a_wake_vector: assert property (p_vec) else $error("wrong vector");
  a_wake_push: assert property (@(posedge mclk) disable iff (sys_rst)
    wake_enter && return_stack_pointer < PMM_SP_W'(PMM_STACK_DEPTH) |=> tos == $past(pc)
    && return_stack_pointer == $past(return_stack_pointer) + 5'h01) else $error("no push");
  a_fetch_wait: assert property (@(posedge mclk) disable iff (sys_rst)
    !core_run |-> !fetch_valid && pc == PMM_RESET_VEC) else $error("early fetch");
  sequence s_hi_req;
    core_run && fetch_req && !fetch_pend && fetch_addr >= mem_top;
  endsequence
  a_zero_fill: assert property (@(posedge mclk) disable iff (sys_rst)
    s_hi_req |=> ##1 fetch_valid && fetch_data == 8'h00) else $error("no zero fill");
  a_cfg_range: assert property (@(posedge mclk) disable iff (sys_rst)
    flash_req && !core_run |-> flash_addr >= mem_top - PMM_CFG_BYTES
    && flash_addr < mem_top - 21'h000002) else $error("bad cfg addr");
  a_pc_even: assert property (@(posedge mclk) disable iff (sys_rst)
    pc[0] == 1'b0) else $error("odd pc");
  a_flash_below: assert property (@(posedge mclk) disable iff (sys_rst)
    flash_req && core_run |-> flash_addr < mem_top) else $error("over top");
  a_load_order: assert property (@(posedge mclk) disable iff (sys_rst)
    state == PMM_LOAD_WAIT && flash_valid |=> cfg_idx == $past(cfg_idx) + 3'h1) else $error("order");
endmodule : pmm_core

// ---- pmm_pkg.sv ----
/*
  Package for the program memory map and configuration loader.
  Assumes a single 100 MHz clock domain and byte-wide flash reads.
*/
package pmm_pkg;
  localparam int          PMM_PC_W        = 21;
  localparam int          PMM_SP_W        = 5;
  localparam int          PMM_STACK_DEPTH = 31;
  localparam logic [20:0] PMM_RESET_VEC   = 21'h000000;
  localparam logic [20:0] PMM_HIGH_VEC    = 21'h000008;
  localparam logic [20:0] PMM_LOW_VEC     = 21'h000018;
  localparam logic [20:0] PMM_TOP_64K     = 21'h010000;
  localparam logic [20:0] PMM_TOP_96K     = 21'h018000;
  localparam logic [20:0] PMM_TOP_128K    = 21'h020000;
  localparam logic [20:0] PMM_CFG_BYTES   = 21'h000008;
  localparam logic [2:0]  PMM_CFG_USED    = 3'h5;
  localparam logic [1:0]  PMM_SIZE_64K    = 2'h0;
  localparam logic [1:0]  PMM_SIZE_96K    = 2'h1;
  localparam logic [1:0]  PMM_SIZE_128K   = 2'h2;
  localparam logic [15:0] PMM_CFG_RESET   = 16'hffff;
  localparam logic [4:0]  PMM_SP_RESET    = 5'h00;

  typedef enum logic [1:0] {PMM_LOAD_REQ, PMM_LOAD_WAIT, PMM_RUN} pmm_state_t;
endpackage : pmm_pkg

// ---- pmm_stack.sv ----
/*
  Return address store: 31 entries of 21 bits, 5-bit pointer.
  Assumes push and pop are never asserted together.
*/
`timescale 1ns/10ps
module pmm_stack
  import pmm_pkg::*;
#(
  parameter int DEPTH = PMM_STACK_DEPTH
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                push,
  input  wire logic                pop,
  input  wire logic [PMM_PC_W-1:0] push_data,
  output logic      [PMM_SP_W-1:0] return_stack_pointer,
  output logic      [PMM_PC_W-1:0] stack_top
);
  // Entry 0 is never written, so a pointer of zero means empty
  logic [PMM_PC_W-1:0] mem [1:DEPTH];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      return_stack_pointer <= PMM_SP_RESET;
    end else if (push && return_stack_pointer < PMM_SP_W'(DEPTH)) begin
      return_stack_pointer <= return_stack_pointer + 5'h01;
    end else if (pop && return_stack_pointer != 5'h00) begin
      return_stack_pointer <= return_stack_pointer - 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!sys_rst && push && return_stack_pointer < PMM_SP_W'(DEPTH)) begin
      mem[return_stack_pointer + 5'h01] <= push_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_top <= '0;
    end else if (push) begin
      stack_top <= push_data;
    end else if (pop && return_stack_pointer > 5'h01) begin
      stack_top <= mem[return_stack_pointer - 5'h01];
    end else if (pop) begin
      stack_top <= '0;
    end
  end
endmodule : pmm_stack

// ---- pmm_flash_model.sv ----
/* Flash array model for pmm_core: byte reads, fast or slow answer.
   Assumes one outstanding request at a time. */
`timescale 1ns/10ps
module pmm_flash_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        flash_req,
  input  wire logic [20:0] flash_addr,
  output logic             flash_valid,
  output logic [7:0]       flash_data
);
  logic [20:0] addr_q;
  logic [2:0]  wait_q;

  // The two bytes of an even-aligned pair differ, so a swapped pair shows
  function automatic logic [7:0] pat(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]} ^ 8'h5a;
  endfunction : pat

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_valid <= 1'b0;
      flash_data  <= 8'h00;
      wait_q      <= 3'h0;
      addr_q      <= 21'h000000;
    end else begin
      flash_valid <= 1'b0;
      if (flash_req) begin
        addr_q <= flash_addr;
        wait_q <= slow ? 3'h4 : 3'h1;
      end else if (wait_q == 3'h1) begin
        flash_valid <= 1'b1;
        flash_data  <= pat(addr_q);
        wait_q      <= 3'h0;
      end else begin
        // Released data lines must not repeat the last byte
        flash_data <= ~flash_data;
        if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule : pmm_flash_model

// ---- testbench.sv ----
/* Self-checking bench for pmm_core against a queue-based model.
   Assumes pmm_flash_model as the flash array. */
`timescale 1ns/10ps
module testbench;
  import pmm_pkg::*;
  logic        mclk, sys_rst, fetch_req, fetch_valid, pc_load, pc_step, stack_pop, wake_irq;
  logic        wake_irq_high, global_irq_enable_high, global_irq_enable_low, flash_req, flash_valid;
  logic        core_run, slow;
  logic [1:0]  flash_size;
  logic [7:0]  fetch_data, flash_data, stack_top_upper, stack_top_high, stack_top_low;
  logic [15:0] setup_word_one, setup_word_two, setup_word_three;
  logic [4:0]  return_stack_pointer;
  logic [20:0] fetch_addr, pc_load_value, flash_addr, pc, top, a;
  int          mismatches, num_checks, cycles, mpc, n, w1;
  int          stk[$];

  pmm_core dut_u (.mclk, .sys_rst, .flash_size, .fetch_req, .fetch_addr, .fetch_valid, .fetch_data,
    .pc_load, .pc_load_value, .pc_step, .stack_pop, .wake_irq, .wake_irq_high, .global_irq_enable_high,
    .global_irq_enable_low, .flash_req, .flash_addr, .flash_valid, .flash_data, .pc, .core_run,
    .setup_word_one, .setup_word_two, .setup_word_three, .return_stack_pointer, .stack_top_upper,
    .stack_top_high, .stack_top_low);
  pmm_flash_model flash_u (.mclk, .sys_rst, .slow, .flash_req, .flash_addr, .flash_valid, .flash_data);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic boot(input logic [1:0] sz);
    top = sz == 2'h2 ? PMM_TOP_128K : sz == 2'h1 ? PMM_TOP_96K : PMM_TOP_64K;
    flash_size = sz;
    sys_rst = 1'b1;
    cyc(12);
    chk("pc_rst", pc, 0);
    chk("w1_rst", setup_word_one, PMM_CFG_RESET);
    sys_rst = 1'b0;
    cyc(1);
    chk("run_early", core_run, 0);
    for (n = 0; n < 300 && core_run !== 1'b1; n++) cyc(1);
    chk("run", core_run, 1);
    chk("w1", setup_word_one, {flash_u.pat(top - 7), flash_u.pat(top - 8)});
    chk("w2", setup_word_two, {flash_u.pat(top - 5), flash_u.pat(top - 6)});
    chk("w3", setup_word_three, {flash_u.pat(top - 3), flash_u.pat(top - 4)});
    chk("pc_boot", pc, 0);
    mpc = 0;
    stk = {};
  endtask : boot

  task automatic fetch(input logic [20:0] fa, input logic [7:0] exp);
    fetch_addr = fa;
    fetch_req = 1'b1;
    cyc(1);
    fetch_req = 1'b0;
    for (n = 0; n < 20 && fetch_valid !== 1'b1; n++) cyc(1);
    chk("fetch_valid", fetch_valid, 1);
    chk("fetch_data", fetch_data, exp);
  endtask : fetch

  task automatic pc_op(input logic ld, input logic [20:0] v);
    pc_load = ld;
    pc_step = !ld;
    pc_load_value = v;
    cyc(1);
    pc_load = 1'b0;
    pc_step = 1'b0;
    mpc = (ld ? v & 21'h1ffffe : mpc + 2) & 32'h1fffff;
    chk("pc", pc, mpc);
    // One edge with the strobes low before the next call raises them
    cyc(1);
  endtask : pc_op

  // Pop or wake, then compare pointer and top of stack with the queue
  task automatic sop(input logic pop, input logic hi, input logic eh, input logic el);
    stack_pop = pop;
    wake_irq = !pop;
    wake_irq_high = hi;
    global_irq_enable_high = eh;
    global_irq_enable_low = el;
    cyc(1);
    stack_pop = 1'b0;
    wake_irq = 1'b0;
    if (pop) void'(stk.pop_back());
    else if (eh || el) begin
      if (stk.size() < 31) stk.push_back(mpc);
      else stk[30] = mpc;
      mpc = hi ? PMM_HIGH_VEC : PMM_LOW_VEC;
    end
    if (!pop) chk("pc_wake", pc, mpc);
    chk("sp", return_stack_pointer, stk.size());
    chk("tos", {stack_top_upper, stack_top_high, stack_top_low}, stk.size() ? stk[$] : 0);
    cyc(1);
  endtask : sop

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    {sys_rst, fetch_req, pc_load, pc_step, stack_pop, wake_irq, wake_irq_high} = 7'h01 << 6;
    {global_irq_enable_high, global_irq_enable_low, slow, flash_size} = 5'h00;
    {fetch_addr, pc_load_value} = 42'h0;
    n = $urandom(32'h699b);
    // Size code 3 is decoded as the smallest flash
    for (int sz = 0; sz < 4; sz++) begin
      boot(sz[1:0]);
      repeat (6) begin
        slow = $urandom_range(1, 0);
        a = $urandom_range(top - 1, 0);
        fetch(a, flash_u.pat(a));
        a = $urandom_range(21'h1fffff, top);
        fetch(a, 8'h00);
      end
      $display("test memory size %0d done", sz);
    end
    w1 = setup_word_one;
    repeat (4) pc_op(1'b1, $urandom);
    pc_op(1'b0, 21'h0);
    $display("test pc done");
    sop(1'b0, 1'b1, 1'b0, 1'b0);
    sop(1'b0, 1'b1, 1'b1, 1'b0);
    sop(1'b0, 1'b0, 1'b0, 1'b1);
    sop(1'b1, 1'b0, 1'b0, 1'b0);
    sop(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (33) begin
      pc_op(1'b1, $urandom);
      sop(1'b0, $urandom, 1'b1, $urandom);
    end
    chk("w1_kept", setup_word_one, w1);
    $display("test stack done");
    tally_and_finish();
  end
endmodule : testbench
